/* File: fault_delay_timer.sv */
// Qualification timer: counts ticks while a fault condition holds
`timescale 1ns/10ps
`default_nettype none

module fault_delay_timer (
   input  wire logic        core_clk,
   input  wire logic        resetn,
   input  wire logic        tick,
   input  wire logic        cond,
   input  wire logic [15:0] limit,
   output logic             expired
);

   pack_prot_pkg::timer_state_t q;   // Registered state
   pack_prot_pkg::timer_state_t d;   // Next state

   // Next state; the count saturates so a held fault stays expired
   always_comb begin
      d = q;
      if (!cond) begin
         d.count   = 16'h0000;
         d.expired = 1'b0;
      end else begin
         if (tick && (q.count != 16'hFFFF)) begin
            d.count = q.count + 16'h0001;
         end
         d.expired = (d.count >= limit);
      end
   end

   // State register
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign expired = q.expired;

   // A dropped condition clears the count and the expiry
   a_timer_restart: assert property (
      @(posedge core_clk) disable iff (!resetn)
      !cond |=> (q.count == 16'h0000) && !expired)
      else $error("delay timer kept counting after its condition dropped");

endmodule : fault_delay_timer

`default_nettype wire

/* File: pack_analog_model.sv */
// Far-side model: cell comparators, current sense and pack terminals
`timescale 1ns/10ps
`default_nettype none

module pack_analog_model (
   input  wire logic       uv_low,               // Some cell sits below the undervoltage level
   input  wire logic       ovl_on,               // Discharge overload current flowing
   input  wire logic       csh_on,               // Charge short current flowing
   input  wire logic       load_on,              // Load still across the pack terminals
   input  wire logic       open_on,              // Sense line of cell 2 broken
   input  wire logic       test_load_enable,
   input  wire logic [2:0] test_cell_select,
   output logic            cell_below_uv,
   output logic            cells_above_uv_hyst,
   output logic            overload_trip,
   output logic            charge_short_trip,
   output logic            load_sense_terminal,
   output logic            cell_collapse
);
   // No cell rests inside the hysteresis band, so the two levels are exact opposites
   assign cell_below_uv       = uv_low;
   assign cells_above_uv_hyst = !uv_low;
   assign overload_trip       = ovl_on;
   assign charge_short_trip   = csh_on;
   // Internal pull-down drags the terminal low once the load is gone
   assign load_sense_terminal = load_on;
   // Only a broken line collapses, and only while the pulsed load sits on it
   assign cell_collapse = open_on && test_load_enable && test_cell_select == 3'h2;
endmodule : pack_analog_model

`default_nettype wire

/* File: pack_fault_protection_fsm.sv */
// Pack fault protection controller: fault qualification, recovery, FET and regulator control
// Functional notes
// - Undervoltage held for delay turns discharge off
// - Recovery select 0: recover on hysteresis only
// - Recovery select 1: hysteresis plus load removal
// - Shutdown enable 1: 8 s below hysteresis
// - Shutdown enable 0: undervoltage never shuts down
// - Shutdown drops regulator; charger insertion wakes
// - Overload held for delay opens both FETs
// - Discharge short held for delay opens both
// - In overload states watch load terminal
// - Overload recovery 0: recover on load removal
// - Overload recovery 1: removal, then charger insertion
// - Charge short held for delay opens both
// - Charge short clears on charger removal
// - Pulse test load per cell each interval
// - Two consecutive detections latch permanent fault
// - Open cell trips within 2N intervals
// - Open-cell fault keeps FETs off
// - Open cell shuts down; wake clears it
// - Charger holds off open-cell shutdown
// - Overvoltage held turns charge off; hysteresis
`timescale 1ns/10ps
`default_nettype none
`include "pack_prot_consts.svh"

module pack_fault_protection_fsm #(
   parameter logic [15:0] SLOW_TICK_CYC = 16'(`SLOW_TICK_CYC),  // Cycles per 1 ms tick
   parameter logic [15:0] OC_CHECK_MS   = 16'(`OC_CHECK_MS)     // Open-cell check interval
) (
   input  wire logic       core_clk,
   input  wire logic       resetn,
   input  wire logic       cell_below_uv,                 // Any cell below undervoltage level
   input  wire logic       cells_above_uv_hyst,           // All cells above level plus hysteresis
   input  wire logic       cell_above_ov,                 // Any cell above overvoltage level
   input  wire logic       cells_below_ov_hyst,           // All cells below level minus hysteresis
   input  wire logic       overload_trip,
   input  wire logic       discharge_short_trip,
   input  wire logic       charge_short_trip,
   input  wire logic       load_sense_terminal,           // High while terminal above open-load
   input  wire logic       charger_present,
   input  wire logic       cell_collapse,                 // Tested cell collapsed under load
   input  wire logic [3:0] pack_cells,                    // Series cells, 4 to 8
   input  wire logic [3:0] undervoltage_threshold_sel,
   input  wire logic [2:0] undervoltage_delay_sel,
   input  wire logic       undervoltage_recovery_select,
   input  wire logic       undervoltage_shutdown_enable,
   input  wire logic [5:0] overvoltage_threshold_sel,
   input  wire logic [2:0] overvoltage_delay_sel,
   input  wire logic       overload_recovery_select,
   input  wire logic [4:0] overload_threshold_sel,
   input  wire logic [4:0] overload_delay_sel,
   input  wire logic [4:0] discharge_short_threshold_sel,
   input  wire logic [4:0] discharge_short_delay_sel,   // Bit 4 selects the slow range
   input  wire logic [4:0] charge_short_threshold_sel,
   input  wire logic [3:0] charge_short_delay_sel,
   output logic            charge_fet_drive,
   output logic            discharge_fet_drive,
   output logic            regulator_enable,
   output logic            test_load_enable,
   output logic [2:0]      test_cell_select,
   output logic [3:0]      uv_cmp_level,
   output logic [5:0]      ov_cmp_level,
   output logic [4:0]      overload_cmp_level,
   output logic [4:0]      dshort_cmp_level,
   output logic [4:0]      cshort_cmp_level,
   output logic            uv_fault_flag,
   output logic            ov_fault_flag,
   output logic            discharge_overload_fault,
   output logic            discharge_short_fault,
   output logic            charge_short_fault,
   output logic            open_cell_fault
);

   pack_prot_pkg::prot_state_t q;                 // Registered state
   pack_prot_pkg::prot_state_t d;                 // Next state
   logic [`CMP_W-1:0]          cmp_raw;           // Unsynchronised comparator inputs
   logic [`TMR_N-1:0]          tmr_cond;          // Timer qualifying conditions
   logic [`TMR_N-1:0]          tmr_tick;          // Timer time base
   logic [`TMR_N-1:0]          tmr_exp;           // Timer expiry
   logic [15:0]                tmr_limit [`TMR_N];
   logic                       active;
   logic                       charger;
   logic                       charger_fall;
   logic                       load;
   logic                       rec_ok;

   // Undervoltage delay: 0.5 s doubling per step, capped at 32 s
   function automatic logic [15:0] uv_limit(input logic [2:0] sel);
      logic [2:0] s;
      s = (sel == 3'h7) ? 3'h6 : sel;
      return `UV_DLY_BASE_MS << s;
   endfunction : uv_limit

   // Overvoltage delay: 0.5 s plus 0.25 s per step
   function automatic logic [15:0] ov_limit(input logic [2:0] sel);
      return `OV_DLY_BASE_MS + `OV_DLY_STEP_MS * {13'h0000, sel};
   endfunction : ov_limit

   // Overload delay: 20 ms steps to 300 ms, then 100 ms steps from 400 ms
   function automatic logic [15:0] ovl_limit(input logic [4:0] sel);
      if (sel < 5'h0F) begin
         return `OVL_DLY_STEP_MS * ({11'h000, sel} + 16'h0001);
      end
      return `OVL_DLY_LONG_MS + `OVL_DLY_LSTEP_MS * ({11'h000, sel} - 16'h000F);
   endfunction : ovl_limit

   // Short blanking: fast range in 60 us ticks, slow range in 50 ms steps
   function automatic logic [15:0] short_limit(input logic slow, input logic [3:0] sel);
      if (slow) begin
         return `DSH_DLY_STEP_MS * ({12'h000, sel} + 16'h0001);
      end
      return {12'h000, sel} + 16'h0001;
   endfunction : short_limit

   assign cmp_raw = {cell_collapse, charger_present, load_sense_terminal, charge_short_trip,
                     discharge_short_trip, overload_trip, cells_below_ov_hyst, cell_above_ov,
                     cells_above_uv_hyst, cell_below_uv};

   // Decoded views of the power mode and the synchronised inputs
   assign active       = (q.pwr == pack_prot_pkg::PWR_ACTIVE);
   assign charger      = q.s2[`CMP_CHGR];
   assign charger_fall = q.charger_prev & ~charger;
   assign load         = q.s2[`CMP_LOAD];

   assign rec_ok = q.load_gone & (~overload_recovery_select | q.charger_seen);

   // Timer conditions; all gated by active so shutdown clears every count
   always_comb begin
      tmr_cond[`TMR_UV]   = active & q.s2[`CMP_UV];
      tmr_cond[`TMR_OV]   = active & q.s2[`CMP_OV];
      tmr_cond[`TMR_OVL]  = active & q.s2[`CMP_OVL];
      tmr_cond[`TMR_DSH]  = active & q.s2[`CMP_DSH];
      tmr_cond[`TMR_CSH]  = active & q.s2[`CMP_CSH];
      // shutdown timer, disabled when bit clear
      tmr_cond[`TMR_UVSD] = active & undervoltage_shutdown_enable & ~q.s2[`CMP_UVH];
      tmr_tick[`TMR_UV]   = q.slow_tick;
      tmr_tick[`TMR_OV]   = q.slow_tick;
      tmr_tick[`TMR_OVL]  = q.slow_tick;
      tmr_tick[`TMR_DSH]  = discharge_short_delay_sel[4] ? q.slow_tick : q.fast_tick;
      tmr_tick[`TMR_CSH]  = q.fast_tick;
      tmr_tick[`TMR_UVSD] = q.slow_tick;
      tmr_limit[`TMR_UV]   = uv_limit(undervoltage_delay_sel);
      tmr_limit[`TMR_OV]   = ov_limit(overvoltage_delay_sel);
      tmr_limit[`TMR_OVL]  = ovl_limit(overload_delay_sel);
      tmr_limit[`TMR_DSH]  = short_limit(discharge_short_delay_sel[4],
                                         discharge_short_delay_sel[3:0]);
      tmr_limit[`TMR_CSH]  = short_limit(1'b0, charge_short_delay_sel);
      tmr_limit[`TMR_UVSD] = `UV_SD_DELAY_MS;
   end

   // One qualification timer per fault source
   genvar gi;
   generate
      for (gi = 0; gi < `TMR_N; gi++) begin : g_tmr
         fault_delay_timer u_tmr (
            .core_clk (core_clk),
            .resetn   (resetn),
            .tick     (tmr_tick[gi]),
            .cond     (tmr_cond[gi]),
            .limit    (tmr_limit[gi]),
            .expired  (tmr_exp[gi])
         );
      end
   endgenerate

   // Next state of the whole controller
   always_comb begin
      d = q;
      // Two-stage synchroniser for every comparator and pin
      d.s1           = cmp_raw;
      d.s2           = q.s1;
      d.charger_prev = charger;
      // Threshold selections forwarded to the comparators
      d.uv_lvl  = undervoltage_threshold_sel;
      d.ov_lvl  = overvoltage_threshold_sel;
      d.ovl_lvl = overload_threshold_sel;
      d.dsh_lvl = discharge_short_threshold_sel;
      d.csh_lvl = charge_short_threshold_sel;
      // Time-base dividers produce one-cycle enables
      d.fast_tick = (q.fast_cnt == 11'(`FAST_TICK_CYC - 1));
      d.fast_cnt  = d.fast_tick ? 11'h000 : q.fast_cnt + 11'h001;
      d.slow_tick = (q.slow_cnt == SLOW_TICK_CYC - 16'h0001);
      d.slow_cnt  = d.slow_tick ? 16'h0000 : q.slow_cnt + 16'h0001;

      case (q.pwr)
         pack_prot_pkg::PWR_ACTIVE: begin
            d.uv = tmr_exp[`TMR_UV] | (q.uv & ~(q.s2[`CMP_UVH] &
                   (~undervoltage_recovery_select | ~load)));
            d.ov = tmr_exp[`TMR_OV] | (q.ov & ~q.s2[`CMP_OVH]);
            d.ovl    = tmr_exp[`TMR_OVL] | (q.ovl & ~rec_ok);
            d.dshort = tmr_exp[`TMR_DSH] | (q.dshort & ~rec_ok);
            // load removal seen below open-load level
            d.load_gone    = (q.ovl | q.dshort) & (q.load_gone | ~load) & ~rec_ok;
            d.charger_seen = q.load_gone & (q.charger_seen | charger) & ~rec_ok;
            d.cshort = tmr_exp[`TMR_CSH] | (q.cshort & ~charger_fall);

            if (!q.ocell) begin
               if (q.oc_test) begin
                  d.oc_cnt = q.oc_cnt + 8'h01;
                  if (q.oc_cnt == 8'(`OC_TEST_CYC - 1)) begin
                     d.oc_test = 1'b0;
                     d.ocell           = q.s2[`CMP_COLL] & q.oc_hit[q.oc_idx];
                     d.oc_hit[q.oc_idx] = q.s2[`CMP_COLL];
                     if ({1'b0, q.oc_idx} >= pack_cells - 4'h1) begin
                        d.oc_idx = 3'h0;
                     end else begin
                        d.oc_idx = q.oc_idx + 3'h1;
                     end
                  end
               end else if (q.slow_tick) begin
                  if (q.oc_ms >= OC_CHECK_MS - 16'h0001) begin
                     d.oc_ms   = 16'h0000;
                     d.oc_test = 1'b1;
                     d.oc_cnt  = 8'h00;
                  end else begin
                     d.oc_ms = q.oc_ms + 16'h0001;
                  end
               end
            end

            // open cell shuts down without charger
            if (tmr_exp[`TMR_UVSD] | (q.ocell & ~charger)) begin
               d.pwr     = pack_prot_pkg::PWR_SHUTDOWN;
               d.oc_test = 1'b0;
            end
         end
         pack_prot_pkg::PWR_SHUTDOWN: begin
            if (charger) begin
               d.pwr          = pack_prot_pkg::PWR_ACTIVE;
               d.uv           = 1'b0;
               d.ov           = 1'b0;
               d.ovl          = 1'b0;
               d.dshort       = 1'b0;
               d.cshort       = 1'b0;
               d.ocell        = 1'b0;
               d.load_gone    = 1'b0;
               d.charger_seen = 1'b0;
               d.oc_hit       = 8'h00;
               d.oc_ms        = 16'h0000;
            end
         end
         default: begin
            d.pwr = pack_prot_pkg::PWR_SHUTDOWN;
         end
      endcase

      // open cell holds both FETs off
      d.cfet   = (d.pwr == pack_prot_pkg::PWR_ACTIVE) & ~d.ov & ~d.ovl & ~d.dshort &
                 ~d.cshort & ~d.ocell;
      d.dfet   = (d.pwr == pack_prot_pkg::PWR_ACTIVE) & ~d.uv & ~d.ovl & ~d.dshort &
                 ~d.cshort & ~d.ocell;
      d.reg_en = (d.pwr == pack_prot_pkg::PWR_ACTIVE);
   end

   // State register; after reset FETs are off and come on a cycle later
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Every output straight from a state flip-flop
   assign charge_fet_drive         = q.cfet;
   assign discharge_fet_drive      = q.dfet;
   assign regulator_enable         = q.reg_en;
   assign test_load_enable         = q.oc_test;
   assign test_cell_select         = q.oc_idx;
   assign uv_cmp_level             = q.uv_lvl;
   assign ov_cmp_level             = q.ov_lvl;
   assign overload_cmp_level       = q.ovl_lvl;
   assign dshort_cmp_level         = q.dsh_lvl;
   assign cshort_cmp_level         = q.csh_lvl;
   assign uv_fault_flag            = q.uv;
   assign ov_fault_flag            = q.ov;
   assign discharge_overload_fault = q.ovl;
   assign discharge_short_fault    = q.dshort;
   assign charge_short_fault       = q.cshort;
   assign open_cell_fault          = q.ocell;

   // Steps of the shutdown and wake sequence
   sequence s_sleeping;
      q.pwr == pack_prot_pkg::PWR_SHUTDOWN && !charger;
   endsequence

   sequence s_wake;
      q.pwr == pack_prot_pkg::PWR_SHUTDOWN && charger;
   endsequence

   a_uv_dsg_off: assert property (
      @(posedge core_clk) disable iff (!resetn)
      (active && tmr_exp[`TMR_UV]) |=> !discharge_fet_drive && uv_fault_flag)
      else $error("discharge FET stayed on after qualified undervoltage");

   a_uv_quick_rec: assert property (
      @(posedge core_clk) disable iff (!resetn)
      (active && q.uv && q.s2[`CMP_UVH] && !undervoltage_recovery_select &&
       !tmr_exp[`TMR_UV] && !tmr_exp[`TMR_UVSD]) |=> !uv_fault_flag)
      else $error("undervoltage did not release at once with recovery select 0");

   a_uv_load_hold: assert property (
      @(posedge core_clk) disable iff (!resetn)
      (active && q.uv && undervoltage_recovery_select && load &&
       !tmr_exp[`TMR_UVSD]) |=> uv_fault_flag)
      else $error("undervoltage released while load still attached");

   a_uv_shutdown: assert property (
      @(posedge core_clk) disable iff (!resetn)
      (active && tmr_exp[`TMR_UVSD]) |=> !regulator_enable && !charge_fet_drive &&
                                         !discharge_fet_drive)
      else $error("long undervoltage did not shut the regulator down");

   a_uv_no_sd: assert property (
      @(posedge core_clk) disable iff (!resetn)
      !$past(undervoltage_shutdown_enable) |-> !tmr_exp[`TMR_UVSD])
      else $error("undervoltage shutdown timer ran while disabled");

   a_sd_stays: assert property (
      @(posedge core_clk) disable iff (!resetn)
      s_sleeping |=> (q.pwr == pack_prot_pkg::PWR_SHUTDOWN) && !regulator_enable)
      else $error("left shutdown without a charger");

   a_wake_clean: assert property (
      @(posedge core_clk) disable iff (!resetn)
      s_wake |=> regulator_enable && !open_cell_fault && !uv_fault_flag)
      else $error("wake from shutdown kept an old fault");

   a_ovl_both_off: assert property (
      @(posedge core_clk) disable iff (!resetn)
      (active && tmr_exp[`TMR_OVL]) |=> !charge_fet_drive && !discharge_fet_drive)
      else $error("FETs stayed on after qualified overload");

   a_dsh_both_off: assert property (
      @(posedge core_clk) disable iff (!resetn)
      (active && tmr_exp[`TMR_DSH]) |=> !charge_fet_drive && !discharge_fet_drive)
      else $error("FETs stayed on after qualified discharge short");

   a_csh_hold: assert property (
      @(posedge core_clk) disable iff (!resetn)
      (active && q.cshort && !charger_fall) |=> charge_short_fault)
      else $error("charge short cleared without charger removal");

   a_ocell_fets: assert property (
      @(posedge core_clk) disable iff (!resetn)
      open_cell_fault |-> !charge_fet_drive && !discharge_fet_drive)
      else $error("FET driven while open-cell fault latched");

endmodule : pack_fault_protection_fsm

`default_nettype wire

/* File: pack_fault_protection_fsm_tb.sv */
// Self-checking bench for the pack fault protection controller
`timescale 1ns/10ps
`default_nettype none

module pack_fault_protection_fsm_tb;
   logic core_clk, resetn, charger_present, uv_low, ovl_on, csh_on, load_on, open_on;
   logic ov_on, dsh_on;     // Some cell above overvoltage, discharge short current flowing
   logic [24:0] lv;         // Random threshold selects
   logic [19:0] dly;        // Delay selects, all shortest
   logic [2:0]  rec;        // Recovery and shutdown selects
   wire  [24:0] lvo;
   wire logic cell_below_uv, cells_above_uv_hyst, overload_trip, charge_short_trip;
   wire logic load_sense_terminal, cell_collapse, test_load_enable, open_cell_fault;
   wire logic charge_fet_drive, discharge_fet_drive, regulator_enable, discharge_overload_fault;
   wire logic uv_fault_flag, ov_fault_flag, charge_short_fault, discharge_short_fault;
   wire logic [2:0] test_cell_select;
   int failures, n_checks, seed, k, fa, fu, fo, sd;   // Model: current faults, UV, OV, shutdown

   pack_analog_model u_far (.uv_low, .ovl_on, .csh_on, .load_on, .open_on, .test_load_enable,
      .test_cell_select, .cell_below_uv, .cells_above_uv_hyst, .overload_trip,
      .charge_short_trip, .load_sense_terminal, .cell_collapse);

   // Slow tick shortened to 20 cycles; check interval 2 ticks
   pack_fault_protection_fsm #(.SLOW_TICK_CYC(16'h0014), .OC_CHECK_MS(16'h0002)) u_dut (
      .core_clk, .resetn, .cell_below_uv, .cells_above_uv_hyst, .cell_above_ov(ov_on),
      .cells_below_ov_hyst(!ov_on), .overload_trip, .discharge_short_trip(dsh_on),
      .charge_short_trip, .load_sense_terminal, .charger_present, .cell_collapse,
      .pack_cells(4'h4), .undervoltage_threshold_sel(lv[24:21]),
      .undervoltage_delay_sel(dly[2:0]), .undervoltage_recovery_select(rec[0]),
      .undervoltage_shutdown_enable(rec[1]), .overvoltage_threshold_sel(lv[20:15]),
      .overvoltage_delay_sel(dly[5:3]), .overload_recovery_select(rec[2]),
      .overload_threshold_sel(lv[14:10]), .overload_delay_sel(dly[10:6]),
      .discharge_short_threshold_sel(lv[9:5]), .discharge_short_delay_sel(dly[15:11]),
      .charge_short_threshold_sel(lv[4:0]), .charge_short_delay_sel(dly[19:16]),
      .charge_fet_drive, .discharge_fet_drive, .regulator_enable, .test_load_enable,
      .test_cell_select, .uv_cmp_level(lvo[24:21]), .ov_cmp_level(lvo[20:15]),
      .overload_cmp_level(lvo[14:10]), .dshort_cmp_level(lvo[9:5]),
      .cshort_cmp_level(lvo[4:0]), .uv_fault_flag, .ov_fault_flag,
      .discharge_overload_fault, .discharge_short_fault, .charge_short_fault,
      .open_cell_fault);

   // 50 ns clock
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = !core_clk;
   end

   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask : cyc

   task automatic chk(input logic [24:0] got, input logic [24:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // Outputs expected from the model's fault state; fa bits: overload, dis. short, chg. short
   task automatic fets();
      chk(25'({charge_fet_drive, discharge_fet_drive, regulator_enable, uv_fault_flag,
               ov_fault_flag, charge_short_fault, discharge_short_fault,
               discharge_overload_fault}),
          25'({fa == 0 && fo == 0 && sd == 0, fa == 0 && fu == 0 && sd == 0, sd == 0,
               fu != 0, fo != 0, 3'(fa)}));
   endtask : fets

   task automatic test_done();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : test_done

   // Watchdog well past the roughly 15000 cycles the sequence needs
   initial begin
      cyc(60000);
      failures++;
      test_done();
   end

   initial begin
      {charger_present, uv_low, ovl_on, csh_on, open_on, ov_on, dsh_on, fa, fu, fo, sd} = '0;
      {failures, n_checks, rec, dly} = '0;
      load_on = 1'b1;
      seed = 32'h5881_75f4;
      lv = 25'($random(seed));
      resetn = 1'b0;
      cyc(2);
      resetn = 1'b1;
      cyc(3);
      fets();
      chk(lvo, lv);
      // Each pulse is under the 400-cycle delay, together far over it: no trip
      for (k = 0; k < 3; k++) begin
         ovl_on = 1'b1;
         cyc(250 + ($random(seed) & 63));
         ovl_on = 1'b0;
         cyc(5);
      end
      fets();
      ovl_on = 1'b1;
      cyc(370);
      fets();
      cyc(40);
      fa = 1;
      fets();
      ovl_on = 1'b0;
      cyc(20);
      fets();
      load_on = 1'b0;
      cyc(6);
      fa = 0;
      fets();
      load_on = 1'b1;
      // Under- and overvoltage: 500 ms is 10000 cycles; no shutdown with the enable at 0
      uv_low = 1'b1;
      ov_on = 1'b1;
      cyc(9400);
      fets();
      cyc(610);
      fu = 1;
      fo = 1;
      fets();
      fets();
      uv_low = 1'b0;
      ov_on = 1'b0;
      cyc(5);
      fu = 0;
      fo = 0;
      fets();
      // Discharge short, fast range; recovery waits for a charger after load removal
      rec[2] = 1'b1;
      dsh_on = 1'b1;
      cyc(1215);
      fa = 2;
      fets();
      dsh_on = 1'b0;
      load_on = 1'b0;
      cyc(20);
      fets();
      load_on = 1'b1;
      charger_present = 1'b1;
      cyc(6);
      fa = 0;
      fets();
      // Charge short: one 60 us fast tick
      charger_present = 1'b1;
      csh_on = 1'b1;
      cyc(1215);
      fa = 4;
      fets();
      csh_on = 1'b0;
      cyc(20);
      fets();
      charger_present = 1'b0;
      cyc(6);
      fa = 0;
      fets();
      // Open sense line on cell 2 of 4
      open_on = 1'b1;
      for (k = 0; k < 2000 && open_cell_fault !== 1'b1; k++) cyc(1);
      chk(25'(k < 2 * 4 * 244), 25'h1);
      cyc(3);
      sd = 1;
      fets();
      open_on = 1'b0;
      charger_present = 1'b1;
      cyc(6);
      sd = 0;
      fets();
      chk(25'(open_cell_fault), 25'h0);
      test_done();
   end
endmodule : pack_fault_protection_fsm_tb

`default_nettype wire

/* File: pack_prot_consts.svh */
// Constants for the pack fault protection controller: timing, indices, field widths
`ifndef PACK_PROT_CONSTS_SVH
`define PACK_PROT_CONSTS_SVH

// Core clock period
`define CLK_PERIOD_NS     50
// Fast time base for short-circuit blanking, 60 us per tick
`define FAST_TICK_NS      60000
`define FAST_TICK_CYC     (`FAST_TICK_NS / `CLK_PERIOD_NS)
// Slow time base, 1 ms per tick
`define SLOW_TICK_NS      1000000
`define SLOW_TICK_CYC     (`SLOW_TICK_NS / `CLK_PERIOD_NS)
// Undervoltage shutdown delay, milliseconds
`define UV_SD_DELAY_MS    16'h1F40
// Open-cell check interval, milliseconds
`define OC_CHECK_MS       250
// Width of one pulsed test load
`define OC_TEST_NS        10000
`define OC_TEST_CYC       (`OC_TEST_NS / `CLK_PERIOD_NS)

// Delay table steps, milliseconds
`define UV_DLY_BASE_MS    16'h01F4
`define OV_DLY_BASE_MS    16'h01F4
`define OV_DLY_STEP_MS    16'h00FA
`define OVL_DLY_STEP_MS   16'h0014
`define OVL_DLY_LONG_MS   16'h0190
`define OVL_DLY_LSTEP_MS  16'h0064
`define DSH_DLY_STEP_MS   16'h0032

// Synchronised comparator vector bit positions
`define CMP_W             10
`define CMP_UV            0
`define CMP_UVH           1
`define CMP_OV            2
`define CMP_OVH           3
`define CMP_OVL           4
`define CMP_DSH           5
`define CMP_CSH           6
`define CMP_LOAD          7
`define CMP_CHGR          8
`define CMP_COLL          9

// Fault timer indices
`define TMR_N             6
`define TMR_UV            0
`define TMR_OV            1
`define TMR_OVL           2
`define TMR_DSH           3
`define TMR_CSH           4
`define TMR_UVSD          5

`endif

/* File: pack_prot_pkg.sv */
// Types shared by the pack fault protection controller and its delay timers
`include "pack_prot_consts.svh"

package pack_prot_pkg;

   // Power mode of the protector
   typedef enum logic {
      PWR_ACTIVE,
      PWR_SHUTDOWN
   } pwr_state_t;

   // Whole state of one delay timer
   typedef struct packed {
      logic [15:0] count;     // Ticks seen while the condition held
      logic        expired;   // Condition held for the full delay
   } timer_state_t;

   // Whole state of the protection controller
   typedef struct packed {
      pwr_state_t         pwr;
      logic [`CMP_W-1:0]  s1;            // First synchroniser stage
      logic [`CMP_W-1:0]  s2;            // Second synchroniser stage
      logic               charger_prev;  // Charger level one cycle back
      logic [10:0]        fast_cnt;
      logic               fast_tick;
      logic [15:0]        slow_cnt;
      logic               slow_tick;
      logic               uv;
      logic               ov;
      logic               ovl;
      logic               dshort;
      logic               cshort;
      logic               ocell;
      logic               load_gone;
      logic               charger_seen;
      logic [15:0]        oc_ms;
      logic [7:0]         oc_cnt;
      logic               oc_test;
      logic [2:0]         oc_idx;
      logic [7:0]         oc_hit;
      logic               cfet;
      logic               dfet;
      logic               reg_en;
      logic [3:0]         uv_lvl;
      logic [5:0]         ov_lvl;
      logic [4:0]         ovl_lvl;
      logic [4:0]         dsh_lvl;
      logic [4:0]         csh_lvl;
   } prot_state_t;

endpackage : pack_prot_pkg
